// >>> core/swwe_engine.sv
// APB-controlled waveform engine for a single-wire open-drain bus.
`timescale 1ns/1ps
module swwe_engine #(
  parameter int US_CYCLES = swwe_pkg::US_CYCLES_DFLT        // clocks per microsecond
) (
  input  wire logic        pclk,       // APB clock, 40 MHz
  input  wire logic        presetn,    // async reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB direction
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error, unmapped address
  input  wire logic        bus_i,      // bus level
  output logic             bus_o,      // bus drive value, always low
  output logic             bus_oe,     // pull bus low
  output logic             spu_en,     // strong pullup on
  output logic             prog_en     // programming supply onto bus
);
  import swwe_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  swwe_cfg_t        cfg_reg;
  swwe_cfg_t        act_reg;
  swwe_cmd_t        cmd_reg;
  swwe_cmd_t        wcmd;
  swwe_state_t      st_reg;
  swwe_state_t      st_next;
  logic [CYC_W-1:0] cyc_reg;
  logic [US_W-1:0]  us_reg;
  logic [US_W-1:0]  seg_len;
  logic [2:0]       bit_reg;
  logic [7:0]       rx_reg;
  logic [7:0]       result_reg;
  logic             pres_reg;
  logic             done_reg;
  logic             refused_reg;
  logic             cur_bit;
  logic             last_bit;
  logic             pulse_inf;
  logic             seg_end;
  logic             acc_en;
  logic             wr_en;
  logic             cmd_wr;
  logic             cmd_go;
  logic             term_go;
  logic             armed_go;
  logic             resp_ev;
  logic [7:0]       resp_val;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_CTRL) || (a == OFS_CMD) || (a == OFS_STATUS) || (a == OFS_RESULT);
  endfunction

  // Segment length for a state; speed and codes come from the latched config
  function automatic logic [US_W-1:0] seg_us(input swwe_state_t s, input swwe_cfg_t c,
                                             input logic b, input logic prog);
    logic od;
    logic fl;
    od = (c.speed == SPD_OD);
    fl = (c.speed == SPD_FLEX);
    case (s)
      S_RST_LOW:   seg_us = od ? RST_LOW_OD_US : RST_LOW_STD_US;
      S_RST_SI:    seg_us = od ? SI_OD_US : SI_STD_US;
      S_RST_PRES:  seg_us = od ? PRES_OFS_OD_US : PRES_OFS_STD_US;
      S_RST_FILL:  seg_us = od ? FILL_OD_US : FILL_STD_US;
      S_RST_SHORT: seg_us = SHORT_WAIT_US;
      S_SLOT_LOW: begin
        if (b)
          seg_us = od ? W1_LOW_OD_US : (fl ? W1_LOW_STD_US + {21'h0, c.w1lt} : W1_LOW_STD_US);
        else
          seg_us = od ? W0_LOW_OD_US : W0_LOW_STD_US;
      end
      S_SLOT_SMP:
        seg_us = od ? SMP_OFS_OD_US : (fl ? SMP_OFS_STD_US + {21'h0, c.smp_ofs} : SMP_OFS_STD_US);
      S_SLOT_HIGH: begin
        if (b)
          seg_us = od ? W1_HIGH_OD_US : W1_HIGH_STD_US;
        else
          seg_us = fl ? W0_REC_US + {21'h0, c.smp_ofs} : W0_REC_US;
      end
      S_PULSE:     seg_us = prog ? (PPD_BASE_US << c.ppd) : swwe_spud_us(c.spud);
      default:     seg_us = 24'h1;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign acc_en = psel && penable && pready;
  assign wr_en  = acc_en && pwrite;
  assign cmd_wr = wr_en && (paddr == OFS_CMD);
  assign wcmd   = swwe_cmd_t'(pwdata[CMD_W-1:0]);

  assign cmd_go   = cmd_wr && (st_reg == S_IDLE) && !wcmd.arm &&
                    ((wcmd.op == OP_RESET) || (wcmd.op == OP_BITS) || (wcmd.op == OP_PULSE));
  // Armed pulses are outside this engine: acknowledged without a pulse
  assign armed_go = cmd_wr && (st_reg == S_IDLE) && wcmd.arm && (wcmd.op == OP_PULSE);
  assign term_go  = cmd_wr && (wcmd.op == OP_TERM) && (st_reg == S_PULSE) && pulse_inf
                    && cfg_reg.cmd_mode;

  // One access cycle: ready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !addr_mapped(paddr);
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_CTRL:   prdata <= {17'h0, cfg_reg};
          OFS_CMD:    prdata <= {16'h0, cmd_reg};
          OFS_STATUS: prdata <= {29'h0, refused_reg, done_reg, st_reg != S_IDLE};
          OFS_RESULT: prdata <= {24'h0, result_reg};
          default:    prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_reg <= swwe_cfg_t'(CTRL_RESET);
    else if (wr_en && paddr == OFS_CTRL)
      cfg_reg <= swwe_cfg_t'(pwdata[CFG_W-1:0]);
  end

  // Config is frozen per command so a mid-sequence write cannot skew a slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= swwe_cfg_t'(CTRL_RESET);
      cmd_reg <= '0;
    end else if (cmd_go || armed_go) begin
      act_reg <= cfg_reg;
      cmd_reg <= wcmd;
    end
  end

  // ----------------------------------------------------------------------
  // Microsecond time base and segment timer
  // ----------------------------------------------------------------------
  assign cur_bit   = cmd_reg.data[bit_reg];
  assign last_bit  = (bit_reg == cmd_reg.nbits - 3'h1);
  assign pulse_inf = cmd_reg.prog ? (act_reg.ppd == DUR_INF)
                                  : (act_reg.spud > SPUD_LAST_FIX);
  assign seg_len   = seg_us(st_reg, act_reg, cur_bit, cmd_reg.prog);
  assign seg_end   = (cyc_reg == CYC_W'(US_CYCLES - 1)) && (us_reg == seg_len - 24'h1)
                     && !(st_reg == S_PULSE && pulse_inf);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= '0;
      us_reg  <= '0;
    end else if (st_next != st_reg) begin
      cyc_reg <= '0;
      us_reg  <= '0;
    end else if (cyc_reg == CYC_W'(US_CYCLES - 1)) begin
      cyc_reg <= '0;
      us_reg  <= us_reg + 24'h1;
    end else begin
      cyc_reg <= cyc_reg + 16'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      S_IDLE: begin
        if (cmd_go) begin
          case (wcmd.op)
            OP_RESET: st_next = S_RST_LOW;
            OP_BITS:  st_next = S_SLOT_LOW;
            default:  st_next = S_PULSE;
          endcase
        end
      end
      S_RST_LOW:   if (seg_end) st_next = S_RST_SI;
      S_RST_SI:    if (seg_end) st_next = bus_i ? S_RST_PRES : S_RST_SHORT;
      S_RST_PRES:  if (seg_end) st_next = S_RST_FILL;
      S_RST_SHORT: if (seg_end) st_next = bus_i ? S_RST_FILL : S_IDLE;
      S_RST_FILL:  if (seg_end) st_next = S_IDLE;
      S_SLOT_LOW:  if (seg_end) st_next = cur_bit ? S_SLOT_SMP : S_SLOT_HIGH;
      S_SLOT_SMP:  if (seg_end) st_next = S_SLOT_HIGH;
      S_SLOT_HIGH: if (seg_end) st_next = last_bit ? S_IDLE : S_SLOT_LOW;
      S_PULSE:     if (seg_end || term_go) st_next = S_IDLE;
      default:     st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      st_reg <= S_IDLE;
    else
      st_reg <= st_next;
  end

  // Bit index and sampled data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_reg <= '0;
      rx_reg  <= '0;
    end else if (cmd_go) begin
      bit_reg <= '0;
      rx_reg  <= wcmd.data;
    end else if (seg_end && st_reg == S_SLOT_SMP) begin
      rx_reg[bit_reg] <= bus_i;
    end else if (seg_end && st_reg == S_SLOT_HIGH) begin
      bit_reg <= bit_reg + 3'h1;
    end
  end

  // Presence sample; a low first sample means alarm or short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pres_reg <= 1'b0;
    else if (cmd_go)
      pres_reg <= 1'b0;
    else if (seg_end && st_reg == S_RST_PRES)
      pres_reg <= !bus_i;
  end

  // ----------------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------------
  always_comb begin
    resp_ev  = 1'b0;
    resp_val = result_reg;
    if (armed_go) begin
      resp_ev  = 1'b1;
      resp_val = RESP_PULSE;
    end else if (st_reg != S_IDLE && st_next == S_IDLE) begin
      resp_ev = 1'b1;
      case (st_reg)
        S_RST_SHORT: resp_val = RESP_SHORT;
        S_RST_FILL:  resp_val = pres_reg ? RESP_PRES : RESP_NOPRES;
        S_SLOT_HIGH: resp_val = rx_reg;
        default:     resp_val = RESP_PULSE;
      endcase
    end
  end

  // Alarm flag rides on the fill after a recovered short test
  logic alarm_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      alarm_reg <= 1'b0;
    else if (cmd_go)
      alarm_reg <= 1'b0;
    else if (seg_end && st_reg == S_RST_SHORT && bus_i)
      alarm_reg <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      result_reg <= '0;
    else if (resp_ev)
      result_reg <= (st_reg == S_RST_FILL && alarm_reg) ? RESP_ALARM : resp_val;
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (resp_ev)
        done_reg <= 1'b1;
      else if (wr_en && paddr == OFS_STATUS && pwdata[ST_DONE])
        done_reg <= 1'b0;
      if (cmd_wr && !cmd_go && !armed_go && !term_go)
        refused_reg <= 1'b1;
      else if (wr_en && paddr == OFS_STATUS && pwdata[ST_REFUSED])
        refused_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Bus drivers, registered from the next state
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_o   <= 1'b0;
      bus_oe  <= 1'b0;
      spu_en  <= 1'b0;
      prog_en <= 1'b0;
    end else begin
      bus_o   <= 1'b0;
      bus_oe  <= (st_next == S_RST_LOW) || (st_next == S_SLOT_LOW);
      spu_en  <= (st_next == S_PULSE) && !(cmd_go ? wcmd.prog : cmd_reg.prog);
      prog_en <= (st_next == S_PULSE) && (cmd_go ? wcmd.prog : cmd_reg.prog);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [31:0] hold_cyc;
  logic        od_act;
  assign od_act = (act_reg.speed == SPD_OD);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_cyc <= '0;
    else if (st_next != st_reg)
      hold_cyc <= '0;
    else
      hold_cyc <= hold_cyc + 32'h1;
  end

  chk_rst_low_len: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_RST_LOW && st_next != S_RST_LOW) |->
      hold_cyc == (od_act ? 64 : 512) * US_CYCLES - 1 && bus_oe)
    else $error("reset low time wrong");

  chk_si_offset: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_RST_SI && st_next != S_RST_SI) |->
      hold_cyc == (od_act ? 2 : 8) * US_CYCLES - 1)
    else $error("short sample offset wrong");

  chk_pres_offset: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_RST_PRES && st_next != S_RST_PRES) |->
      hold_cyc == (od_act ? 8 : 64) * US_CYCLES - 1 ##1 st_reg == S_RST_FILL)
    else $error("presence offset wrong");

  chk_fill_resp: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_RST_FILL && st_next == S_IDLE) |->
      hold_cyc == (od_act ? 64 : 512) * US_CYCLES - 1 ##1 done_reg)
    else $error("fill delay or response wrong");

  chk_short_code: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_RST_SHORT && seg_end && !bus_i) |=>
      result_reg == RESP_SHORT && done_reg && st_reg == S_IDLE)
    else $error("short response missing");

  chk_alarm_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_RST_SHORT && seg_end && bus_i) |=>
      st_reg == S_RST_FILL && alarm_reg)
    else $error("alarm path wrong");

  chk_weak_only: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg inside {S_RST_SI, S_RST_PRES, S_RST_FILL, S_RST_SHORT}) |->
      !bus_oe && !spu_en && !prog_en)
    else $error("bus driven in reset high phase");

  chk_back_to_back: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_SLOT_HIGH && seg_end && !last_bit) |=> st_reg == S_SLOT_LOW ##0 bus_oe)
    else $error("gap between slots");

  chk_term_end: assert property (@(posedge pclk) disable iff (!presetn)
    term_go |=> !spu_en && !prog_en && done_reg && result_reg == RESP_PULSE)
    else $error("termination did not end pulse");

  chk_term_data: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && wcmd.op == OP_TERM && st_reg == S_PULSE && !cfg_reg.cmd_mode && !seg_end) |=>
      st_reg == S_PULSE)
    else $error("termination acted in data mode");

  chk_w0_low_len: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_SLOT_LOW && st_next != S_SLOT_LOW && !cur_bit) |->
      hold_cyc == (od_act ? 7 : 57) * US_CYCLES - 1 && bus_oe)
    else $error("write-0 low time wrong");

  chk_resp_prompt: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == S_SLOT_HIGH && st_next == S_IDLE) |=> done_reg && result_reg == rx_reg)
    else $error("byte response not prompt");

  chk_pulse_start: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && wcmd.op == OP_PULSE) |=> st_reg == S_PULSE && (spu_en || prog_en))
    else $error("pulse did not start at once");

endmodule // swwe_engine

// >>> core/swwe_pkg.sv
// Constants, types and register map of the single-wire waveform engine.
// Behaviour
// - Reset: hold bus low 512/64 us
// - Release, wait 8/2 us, sample for low
// - High sample: wait 64/8 us, sample presence
// - Then wait fill 512/64 us, respond
// - Low sample: wait 4096 us; still low, short
// - Recovered: fill, alarm code, no presence test
// - Same short test at overdrive speed
// - Reset high phase: weak pullup only
// - Write-1 slot: low, offset, sample, high
// - Write-0 slot: low 57/7 us, recover 3
// - Slots of one command run back to back
// - Response as soon as last slot ends
// - Codes below limit give predefined pulse length
// - Code 111 holds pulse until terminated
// - Pulse behaviour applies only when disarmed
// - Pullup and programming pulse sequence identically
// - Pulse starts at once, then response
// - Termination ends pulse, pulse response only; code ends only an endless pulse, refuses others
// - Termination works only in command mode
package swwe_pkg;

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int US_PS          = 1000000;
  localparam int US_CYCLES_DFLT = US_PS / CLK_PERIOD_PS;
  localparam int US_W           = 24;
  localparam int CYC_W          = 16;

  // ----------------------------------------------------------------------
  // Segment times in microseconds
  // ----------------------------------------------------------------------
  localparam logic [US_W-1:0] RST_LOW_STD_US  = 24'h200;
  localparam logic [US_W-1:0] RST_LOW_OD_US   = 24'h40;
  localparam logic [US_W-1:0] SI_STD_US       = 24'h8;
  localparam logic [US_W-1:0] SI_OD_US        = 24'h2;
  localparam logic [US_W-1:0] PRES_OFS_STD_US = 24'h40;
  localparam logic [US_W-1:0] PRES_OFS_OD_US  = 24'h8;
  localparam logic [US_W-1:0] FILL_STD_US     = 24'h200;
  localparam logic [US_W-1:0] FILL_OD_US      = 24'h40;
  localparam logic [US_W-1:0] SHORT_WAIT_US   = 24'h1000;
  localparam logic [US_W-1:0] W1_LOW_STD_US   = 24'h8;
  localparam logic [US_W-1:0] W1_LOW_OD_US    = 24'h1;
  localparam logic [US_W-1:0] SMP_OFS_STD_US  = 24'h3;
  localparam logic [US_W-1:0] SMP_OFS_OD_US   = 24'h1;
  localparam logic [US_W-1:0] W1_HIGH_STD_US  = 24'h31;
  localparam logic [US_W-1:0] W1_HIGH_OD_US   = 24'h8;
  localparam logic [US_W-1:0] W0_LOW_STD_US   = 24'h39;
  localparam logic [US_W-1:0] W0_LOW_OD_US    = 24'h7;
  localparam logic [US_W-1:0] W0_REC_US       = 24'h3;
  localparam logic [US_W-1:0] PPD_BASE_US     = 24'h20;
  localparam logic [2:0]      DUR_INF        = 3'h7;
  localparam logic [2:0]      SPUD_LAST_FIX  = 3'h5;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CMD     = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_RESULT  = 8'h0C;
  localparam int          CFG_W       = 15;
  localparam int          CMD_W       = 16;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_DONE     = 1;
  localparam int          ST_REFUSED  = 2;
  localparam logic [14:0] CTRL_RESET  = 15'h0004;

  localparam logic [1:0] SPD_STD  = 2'h0;
  localparam logic [1:0] SPD_FLEX = 2'h1;
  localparam logic [1:0] SPD_OD   = 2'h2;

  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_BITS  = 3'h2;
  localparam logic [2:0] OP_PULSE = 3'h3;
  localparam logic [2:0] OP_TERM  = 3'h4;

  localparam logic [7:0] RESP_SHORT  = 8'hCC;
  localparam logic [7:0] RESP_PRES   = 8'hCD;
  localparam logic [7:0] RESP_ALARM  = 8'hCE;
  localparam logic [7:0] RESP_NOPRES = 8'hCF;
  localparam logic [7:0] RESP_PULSE  = 8'hEC;

  typedef struct packed {
    logic [2:0] spud;      // pullup duration code
    logic [2:0] ppd;       // programming duration code
    logic [2:0] smp_ofs;   // sample offset / recovery code
    logic [2:0] w1lt;      // write-1 low time code
    logic       cmd_mode;  // 1 = command mode
    logic [1:0] speed;
  } swwe_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] nbits;     // 0 means eight
    logic       arm;
    logic       prog;      // 1 = programming pulse
    logic [2:0] op;
  } swwe_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE      = 4'b0000,
    S_RST_LOW   = 4'b0001,
    S_RST_SI    = 4'b0011,
    S_RST_PRES  = 4'b0010,
    S_RST_FILL  = 4'b0110,
    S_RST_SHORT = 4'b0111,
    S_SLOT_LOW  = 4'b0101,
    S_SLOT_SMP  = 4'b0100,
    S_SLOT_HIGH = 4'b1100,
    S_PULSE     = 4'b1101
  } swwe_state_t;

  function automatic logic [US_W-1:0] swwe_spud_us(input logic [2:0] code);
    case (code)
      3'h0:    swwe_spud_us = 24'h4010;
      3'h1:    swwe_spud_us = 24'hFFDC;
      3'h2:    swwe_spud_us = 24'h1FFB8;
      3'h3:    swwe_spud_us = 24'h3FF70;
      3'h4:    swwe_spud_us = 24'h7FEE0;
      default: swwe_spud_us = 24'hFFDC0;
    endcase
  endfunction

endpackage

// >>> core/unused_placeholder_none.sv
// Intentionally empty design unit holder.
`timescale 1ns/1ps

// >>> test/swwe_slave.sv
// Behavioural slave devices hanging on the single-wire bus.
`timescale 1ns/1ps
module swwe_slave #(
  parameter int U = 2           // clocks per microsecond
) (
  input  wire logic       pclk,   // engine clock
  input  wire logic       bus_oe, // engine sinks the bus
  input  wire logic [1:0] mode,   // 0 none, 1 presence, 2 short, 3 alarm
  input  wire logic [7:0] rd_pat, // levels returned in read slots
  output logic            bus_i   // resolved bus level
);
  int   low_len = 0;
  int   rel     = 0;
  int   idx     = 0;
  logic pull;

  // Slot index restarts after a long idle gap
  always_ff @(posedge pclk) begin
    if (bus_oe) begin
      low_len <= (rel != 0) ? 1 : low_len + 1;
      rel     <= 0;
      if (rel != 0) idx <= idx + 1;
    end else begin
      rel <= rel + 1;
      if (rel > 200 * U) idx <= 0;
    end
  end

  always_comb begin
    if (low_len >= 60 * U)
      pull = (mode == 2'h1 && rel >= 9 * U && rel < 100 * U) ||
             (mode == 2'h2 && rel < 5000 * U) || (mode == 2'h3 && rel < 100 * U);
    else
      pull = low_len < 20 * U && rel < 15 * U && idx > 0 && !rd_pat[3'(idx - 1)];
  end

  // Pulled up whenever nobody sinks it
  assign bus_i = !(bus_oe || pull);
endmodule // swwe_slave

// >>> test/tb.sv
// Self-checking bench for the single-wire waveform engine.
`timescale 1ns/1ps
module tb;
  import swwe_pkg::*;
  localparam int U = 2;
  localparam logic [7:0] TBL [4] = '{RESP_NOPRES, RESP_PRES, RESP_SHORT, RESP_ALARM};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, rd_pat = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, bus_i, bus_o, bus_oe, spu_en, prog_en, last_err;
  logic [1:0]  mode = 2'h0;
  int          err_total = 0, check_count = 0, oe_cnt = 0, pe_cnt = 0, sp_cnt = 0, s0, s1;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    oe_cnt <= oe_cnt + (bus_oe === 1'b1);
    pe_cnt <= pe_cnt + (prog_en === 1'b1);
    sp_cnt <= sp_cnt + (spu_en === 1'b1);
  end

  swwe_engine #(.US_CYCLES(U)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bus_i, .bus_o, .bus_oe, .spu_en, .prog_en);
  swwe_slave #(.U(U)) slv (.pclk, .bus_oe, .mode, .rd_pat, .bus_i);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Idle cycle, setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata; last_err = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50) begin err_total++; finish_test(); end
  endtask

  task automatic run(input logic [31:0] cmd);
    int n;
    apb(1, OFS_CMD, cmd);
    for (n = 0; n < 8000; n++) begin
      apb(0, OFS_STATUS, 0);
      if (r[ST_DONE] === 1'b1) break;
    end
    if (n >= 8000) begin err_total++; finish_test(); end
    apb(1, OFS_STATUS, 32'h2);
    apb(0, OFS_RESULT, 0);
  endtask

  task automatic setc(input logic [1:0] sp, input logic cm, input logic [2:0] w1,
                      input logic [2:0] ds, input logic [2:0] pp, input logic [2:0] su);
    apb(1, OFS_CTRL, {17'h0, su, pp, ds, w1, cm, sp});
  endtask

  function automatic logic [7:0] exp_bits(logic [7:0] d, logic [7:0] p, logic [2:0] n);
    exp_bits = d;
    for (int i = 0; i < 8; i++) if (n == 0 || i < n) exp_bits[i] = d[i] & p[i];
  endfunction

  initial begin
    logic [7:0] d;
    logic [2:0] c1, c2, nb;
    s0 = $urandom(32'h36d2138a);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_CTRL, 0); check(r, CTRL_RESET);
    apb(0, 8'h10, 0);
    check(last_err, 1);
    for (int i = 0; i < 4; i++) begin
      mode <= i[1:0];
      setc(2'(i % 3), 1, 0, 0, 0, 0);
      s0 = oe_cnt;
      run(OP_RESET);
      check(oe_cnt - s0, (i == 2 ? 64 : 512) * U);
      check(r[7:0], TBL[i]);
    end
    mode <= 2'h0;
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom); rd_pat <= 8'($urandom); c1 = 3'($urandom);
      nb = (i == 0) ? 3'h0 : 3'($urandom);
      c2 = 3'($urandom % (c1 > 4 ? 12 - c1 : 8));
      setc(2'(i % 3), 1, c1, c2, 0, 0);
      repeat (250 * U) @(posedge pclk);
      run({16'h0, d, nb, 2'b00, OP_BITS});
      check(r[7:0], exp_bits(d, rd_pat, nb));
    end
    setc(0, 1, 0, 0, 0, 0);
    s0 = pe_cnt; s1 = sp_cnt;
    run({27'h0, 2'b01, OP_PULSE});
    check(r[7:0], RESP_PULSE);
    check(pe_cnt - s0, 32 * U);
    check(sp_cnt - s1, 0);
    check(bus_o, 0);
    s0 = pe_cnt;
    run({27'h0, 2'b11, OP_PULSE});
    check(pe_cnt - s0, 0);
    setc(0, 1, 0, 0, 7, 0);
    apb(1, OFS_CMD, {27'h0, 2'b01, OP_PULSE});
    repeat (300) @(posedge pclk);
    check(prog_en, 1);
    run(OP_TERM);
    check(r[7:0], RESP_PULSE);
    check(prog_en, 0);
    setc(0, 0, 0, 0, 0, 7);
    apb(1, OFS_CMD, {27'h0, 2'b00, OP_PULSE});
    repeat (300) @(posedge pclk);
    apb(1, OFS_CMD, OP_TERM);
    apb(0, OFS_STATUS, 0);
    check(r[ST_REFUSED], 1);
    check(spu_en, 1);
    presetn <= 0;
    @(posedge pclk) presetn <= 1;
    @(posedge pclk) check(spu_en, 0);
    finish_test();
  end
endmodule // tb
